// ==== ifm_edge_sync.sv ====
`timescale 1ns/1ps
`include "ifm_map.svh"

module ifm_edge_sync (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [`IFM_NUM_PORTS-1:0] pin_in,
    output logic [`IFM_NUM_PORTS-1:0] level,
    output logic [`IFM_NUM_PORTS-1:0] rise,
    output logic [`IFM_NUM_PORTS-1:0] fall
);

    genvar gi;
    generate
        for (gi = 0; gi < `IFM_NUM_PORTS; gi++) begin : g_port
            logic meta_r;
            logic sync_r;
            logic prev_r;
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_r <= 1'b0;
                    sync_r <= 1'b0;
                    prev_r <= 1'b0;
                end else if (clk_en) begin
                    meta_r <= pin_in[gi];
                    sync_r <= meta_r;
                    prev_r <= sync_r;
                end
            end
            assign level[gi] = sync_r;
            // edges come only from the second stage and its delayed copy
            assign rise[gi] = sync_r & ~prev_r;
            assign fall[gi] = ~sync_r & prev_r;
        end
    endgenerate

endmodule : ifm_edge_sync

// ==== ifm_input_mapper.sv ====
`timescale 1ns/1ps
`include "ifm_map.svh"

// Notes on behaviour
// R1: each selection takes 0..5; zero keeps the port a plain input.
// R2: port one, selection one: restart after one second held active.
// R3: enable restart input when emergency stop continues operation.
// R4: port two, selection one: rising edge switches servo on, all axes.
// R5: port two, selection one: falling edge switches servo off, all axes.
// R6: sequencer spaces servo input transitions at least 1.5 s apart.
// R7: sequencer toggles servo input only while controller is idle.
// R8: port three, selection one: plain input; auto-start after reset in AUTO.
// R9: port three, selection two: rise starts auto program, fall aborts all.
// R10: sequencer holds auto-start input active at least 100 ms.
// R11: inputs are synchronised, edges taken from the synchronised level.
module ifm_input_mapper #(
    parameter int unsigned HOLD_CYCLES = `IFM_HOLD_MS * `IFM_CLK_KHZ
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [`IFM_NUM_PORTS-1:0] pin_in,
    input wire ifm_pkg::ifm_sel_t sel_restart,
    input wire ifm_pkg::ifm_sel_t sel_servo,
    input wire ifm_pkg::ifm_sel_t sel_auto,
    input wire logic auto_mode,
    output logic [`IFM_NUM_PORTS-1:0] gp_in,
    output logic sw_restart,
    output logic servo_on_cmd,
    output logic servo_off_cmd,
    output logic auto_start,
    output logic abort_all
);

    localparam logic [`IFM_CNT_W-1:0] HOLD_LIM = HOLD_CYCLES[`IFM_CNT_W-1:0];

    logic [`IFM_NUM_PORTS-1:0] lvl;
    logic [`IFM_NUM_PORTS-1:0] rise;
    logic [`IFM_NUM_PORTS-1:0] fall;
    logic [`IFM_NUM_PORTS-1:0] gp_in_r;
    logic [`IFM_CNT_W-1:0] hold_cnt_r;
    logic [`IFM_CNT_W-1:0] hold_cnt_nxt;
    logic restart_r;
    logic servo_on_r;
    logic servo_off_r;
    logic auto_start_r;
    logic abort_r;
    logic restart_held;
    logic restart_fire;
    logic boot_launch;
    ifm_pkg::ifm_boot_t boot_r;

    // R11: two-stage sync
    ifm_edge_sync u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .pin_in(pin_in),
        .level(lvl),
        .rise(rise),
        .fall(fall)
    );

    // R1: general-purpose view of each port
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gp_in_r <= '0;
        end else if (clk_en) begin
            gp_in_r[`IFM_PORT_RESTART] <= (sel_restart == `IFM_SEL_GP) & lvl[`IFM_PORT_RESTART];
            gp_in_r[`IFM_PORT_SERVO] <= (sel_servo == `IFM_SEL_GP) & lvl[`IFM_PORT_SERVO];
            // R8: selection one keeps port three general-purpose
            gp_in_r[`IFM_PORT_AUTO] <= ((sel_auto == `IFM_SEL_GP) | (sel_auto == `IFM_SEL_F1))
                                       & lvl[`IFM_PORT_AUTO];
        end
    end

    // R2: one-second hold counter
    assign restart_held = (sel_restart == `IFM_SEL_F1) & lvl[`IFM_PORT_RESTART];
    assign restart_fire = restart_held & (hold_cnt_r == HOLD_LIM - `IFM_CNT_W'(1));

    // counter saturates at the limit so one long hold fires only once
    always_comb begin
        hold_cnt_nxt = hold_cnt_r;
        if (!restart_held) begin
            hold_cnt_nxt = '0;
        end else if (hold_cnt_r != HOLD_LIM) begin
            hold_cnt_nxt = hold_cnt_r + `IFM_CNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_cnt_r <= '0;
            restart_r <= 1'b0;
        end else if (clk_en) begin
            hold_cnt_r <= hold_cnt_nxt;
            restart_r <= restart_fire;
        end
    end

    // R4 R5: servo commands on edges
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            servo_on_r <= 1'b0;
            servo_off_r <= 1'b0;
        end else if (clk_en) begin
            servo_on_r <= (sel_servo == `IFM_SEL_F1) & rise[`IFM_PORT_SERVO];
            servo_off_r <= (sel_servo == `IFM_SEL_F1) & fall[`IFM_PORT_SERVO];
        end
    end

    // R8: launch pending after power-on or own restart
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_r <= ifm_pkg::BOOT_WAIT;
        end else if (clk_en) begin
            case (boot_r)
                ifm_pkg::BOOT_WAIT: boot_r <= ifm_pkg::BOOT_IDLE;
                ifm_pkg::BOOT_IDLE: begin
                    if (restart_r) begin
                        boot_r <= ifm_pkg::BOOT_WAIT;
                    end
                end
                default: boot_r <= ifm_pkg::BOOT_IDLE;
            endcase
        end
    end

    assign boot_launch = (boot_r == ifm_pkg::BOOT_WAIT) & (sel_auto == `IFM_SEL_F1) & auto_mode;

    // R9: auto-start start and abort
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            auto_start_r <= 1'b0;
            abort_r <= 1'b0;
        end else if (clk_en) begin
            auto_start_r <= boot_launch | ((sel_auto == `IFM_SEL_F2) & rise[`IFM_PORT_AUTO]);
            abort_r <= (sel_auto == `IFM_SEL_F2) & fall[`IFM_PORT_AUTO];
        end
    end

    assign gp_in = gp_in_r;
    assign sw_restart = restart_r;
    assign servo_on_cmd = servo_on_r;
    assign servo_off_cmd = servo_off_r;
    assign auto_start = auto_start_r;
    assign abort_all = abort_r;

    // checks are off in reset and while the clock enable freezes state
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n || !clk_en);

    sequence s_restart_then_auto;
        restart_r ##1 ((sel_auto == `IFM_SEL_F1) && auto_mode);
    endsequence

    sequence s_held_release;
        restart_held ##1 !restart_held;
    endsequence

    AST_SERVO_ON: assert property ( // R4
        ((sel_servo == `IFM_SEL_F1) && rise[`IFM_PORT_SERVO]) |=> servo_on_cmd)
        else $error("servo on command missing after rising edge");

    AST_SERVO_OFF: assert property ( // R5
        ((sel_servo == `IFM_SEL_F1) && fall[`IFM_PORT_SERVO]) |=> servo_off_cmd && !servo_on_cmd)
        else $error("servo off command missing after falling edge");

    AST_SEL_GP_QUIET: assert property ( // R1
        (sel_servo == `IFM_SEL_GP) |=> !servo_on_cmd && !servo_off_cmd
            && (gp_in[`IFM_PORT_SERVO] == $past(lvl[`IFM_PORT_SERVO])))
        else $error("general-purpose servo port produced a command");

    AST_RESTART_HOLD: assert property ( // R2
        sw_restart |-> (hold_cnt_r == HOLD_LIM) && $past(restart_held))
        else $error("restart pulse without full hold time");

    AST_RESTART_RELEASE: assert property ( // R2
        s_held_release |=> (hold_cnt_r == '0) && !sw_restart)
        else $error("hold counter not cleared on release");

    AST_RESTART_BOOT: assert property ( // R8
        s_restart_then_auto |=> auto_start)
        else $error("auto-start not launched after restart");

    AST_AUTO_RISE: assert property ( // R9
        ((sel_auto == `IFM_SEL_F2) && rise[`IFM_PORT_AUTO]) |=> auto_start && !abort_all)
        else $error("auto-start missing after rising edge");

    AST_AUTO_ABORT: assert property ( // R9
        ((sel_auto == `IFM_SEL_F2) && fall[`IFM_PORT_AUTO]) |=> abort_all)
        else $error("abort missing after falling edge");

    AST_EDGE_FROM_SYNC: assert property ( // R11
        servo_on_cmd |-> $past(lvl[`IFM_PORT_SERVO]) && !$past(lvl[`IFM_PORT_SERVO], 2))
        else $error("servo command not from synchronised edge");

    AST_SERVO_ON_ONCE: assert property ( // R4
        servo_on_cmd |=> !servo_on_cmd)
        else $error("servo on command longer than one cycle");

    AST_SERVO_OFF_ONCE: assert property ( // R5
        servo_off_cmd |=> !servo_off_cmd)
        else $error("servo off command longer than one cycle");

    AST_RESTART_SEL_QUIET: assert property ( // R1
        (sel_restart != `IFM_SEL_F1) |=> !sw_restart)
        else $error("restart pulse with restart function not selected");

    AST_ABORT_SEL_QUIET: assert property ( // R1
        (sel_auto != `IFM_SEL_F2) |=> !abort_all)
        else $error("abort pulse with start function not selected");

    AST_AUTO_GP_LEVEL: assert property ( // R8
        (sel_auto == `IFM_SEL_F1) |=> (gp_in[`IFM_PORT_AUTO] == $past(lvl[`IFM_PORT_AUTO])))
        else $error("port three not shown as plain input");

    AST_NO_LAUNCH_OFF_AUTO: assert property ( // R8
        ((boot_r == ifm_pkg::BOOT_WAIT) && !auto_mode && (sel_auto != `IFM_SEL_F2))
            |=> !auto_start)
        else $error("auto-start launched outside AUTO mode");

endmodule : ifm_input_mapper

// ==== ifm_map.svh ====
`ifndef IFM_MAP_SVH
`define IFM_MAP_SVH

// selection codes
`define IFM_SEL_GP 3'h0
`define IFM_SEL_F1 3'h1
`define IFM_SEL_F2 3'h2

// input port bit positions
`define IFM_PORT_RESTART 0
`define IFM_PORT_SERVO 1
`define IFM_PORT_AUTO 2
`define IFM_NUM_PORTS 3

// timing
`define IFM_HOLD_MS 1000
`define IFM_CLK_KHZ 200000
`define IFM_CNT_W 28

`endif

// ==== ifm_pkg.sv ====
package ifm_pkg;

    typedef logic [2:0] ifm_sel_t;

    typedef enum logic {
        BOOT_WAIT,
        BOOT_IDLE
    } ifm_boot_t;

endpackage : ifm_pkg

// ==== ifm_seq_model.sv ====
`timescale 1ns/1ps

// external sequencer: presents the requested levels on the pins at the falling edge
module ifm_seq_model (
    input wire logic ref_clk,
    input wire logic [2:0] req,
    output logic [2:0] pin_in
);
    logic [2:0] req_r;
    initial pin_in = 3'h0;
    // spacing held by caller
    // request taken at the rising edge so the pin moves at a fixed falling edge
    always @(posedge ref_clk) begin
        req_r <= req;
    end
    always @(negedge ref_clk) begin
        pin_in <= req_r;
    end
endmodule : ifm_seq_model

// ==== tb_input_function_mapper.sv ====
`timescale 1ns/1ps

module tb_input_function_mapper;
    localparam int HOLD = 20;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic auto_mode = 1'b1;
    logic [2:0] req = 3'h0;
    logic [2:0] pin_in;
    ifm_pkg::ifm_sel_t sel_restart = 3'h0;
    ifm_pkg::ifm_sel_t sel_servo = 3'h0;
    ifm_pkg::ifm_sel_t sel_auto = 3'h1;
    logic [2:0] gp_in;
    logic sw_restart, servo_on_cmd, servo_off_cmd, auto_start, abort_all;
    int cnt[5];
    int n_mismatch = 0;
    int num_checks = 0;
    int seed = 32'hA9990C71;
    int s;

    ifm_seq_model i_seq (.ref_clk(ref_clk), .req(req), .pin_in(pin_in));
    ifm_input_mapper #(.HOLD_CYCLES(HOLD)) i_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .pin_in(pin_in),
        .sel_restart(sel_restart), .sel_servo(sel_servo), .sel_auto(sel_auto),
        .auto_mode(auto_mode), .gp_in(gp_in), .sw_restart(sw_restart),
        .servo_on_cmd(servo_on_cmd), .servo_off_cmd(servo_off_cmd),
        .auto_start(auto_start), .abort_all(abort_all));

    always #2.5 ref_clk = ~ref_clk;

    // pulse tally per command output
    always @(posedge ref_clk) begin
        cnt[0] += (sw_restart === 1'b1);
        cnt[1] += (servo_on_cmd === 1'b1);
        cnt[2] += (servo_off_cmd === 1'b1);
        cnt[3] += (auto_start === 1'b1);
        cnt[4] += (abort_all === 1'b1);
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
            n_mismatch++;
        end
    endtask : chk

    task automatic wait_n(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : wait_n

    task automatic clr();
        cnt = '{default: 0};
    endtask : clr

    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    initial begin
        clr();
        wait_n(10);
        rst_n = 1'b1;
        wait_n(8);
        chk(cnt[3], 1);
        clr();
        sel_servo = 3'h1;
        req[1] = 1'b1;
        wait_n(8);
        chk(cnt[1], 1);
        req[1] = 1'b0;
        wait_n(8);
        chk(cnt[2], 1);
        chk(cnt[1], 1);
        // other selections must stay silent; zero shows the level
        for (int i = 0; i < 6; i++) begin
            s = (i == 0) ? 0 : (i == 1) ? 2 : 3 + $unsigned($random(seed)) % 3;
            sel_servo = 3'(s);
            clr();
            req[1] = 1'b1;
            wait_n(6);
            chk(gp_in[1], (s == 0));
            req[1] = 1'b0;
            wait_n(6);
            chk(cnt[1] + cnt[2], 0);
        end
        sel_servo = 3'h0;
        sel_auto = 3'h2;
        clr();
        req[2] = 1'b1;
        wait_n(8);
        chk(cnt[3], 1);
        req[2] = 1'b0;
        wait_n(8);
        chk(cnt[4], 1);
        sel_auto = 3'h1;
        sel_restart = 3'h1;
        clr();
        req[0] = 1'b1;
        wait_n(HOLD - 5);
        req[0] = 1'b0;
        wait_n(8);
        chk(cnt[0], 0);
        req[0] = 1'b1;
        wait_n(HOLD + 10);
        chk(cnt[0], 1);
        chk(cnt[3], 1);
        wait_n(30);
        chk(cnt[0], 1);
        req[0] = 1'b0;
        wait_n(6);
        sel_restart = 3'h0;
        clr();
        req[0] = 1'b1;
        wait_n(HOLD + 20);
        chk(cnt[0], 0);
        chk(gp_in[0], 1'b1);
        req[0] = 1'b0;
        rst_n = 1'b0;
        auto_mode = 1'b0;
        wait_n(3);
        clr();
        rst_n = 1'b1;
        wait_n(8);
        chk(cnt[3], 0);
        sel_auto = 3'h0;
        clr();
        for (int i = 0; i < 12; i++) begin
            req = 3'($random(seed));
            wait_n(5);
            chk(gp_in, req);
        end
        // clock enable low freezes the sync chain and outputs
        clk_en = 1'b0;
        s = gp_in;
        req = ~req;
        wait_n(6);
        chk(gp_in, s);
        clk_en = 1'b1;
        wait_n(5);
        chk(gp_in, req);
        chk(cnt[1] + cnt[2] + cnt[4], 0);
        end_of_test();
    end
endmodule : tb_input_function_mapper
